/* hw/error_group_irq_status_regs.sv */
// Register front end of the error group: extension, interrupt
// configuration, interrupt status and low identity registers.
// Assumes a simple 64-bit memory-mapped request port on core_clk.
`timescale 1ns/10ps
`default_nettype none
module error_group_irq_status_regs
    import err_group_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      bus_req,
    input  wire logic                      bus_write,
    input  wire logic [ADDR_W-1:0]         bus_addr,
    input  wire logic [DATA_W-1:0]         bus_wdata,
    output logic      [DATA_W-1:0]         bus_rdata,
    output logic                           bus_ack,
    input  wire logic                      fault_inject_present,
    input  wire logic [15:0]               record_count_field,
    input  wire logic [KIND_COUNT-1:0]     msg_start,
    input  wire logic [KIND_COUNT-1:0]     msg_done,
    input  wire logic [KIND_COUNT-1:0]     msg_err,
    output logic [KIND_COUNT-1:0]          write_busy,
    output logic [KIND_COUNT-1:0]          write_error
);
    import err_group_pkg::*;

    // Offset falls in a table of 8-byte slots starting at base
    function automatic logic in_table(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base,
        input int                count
    );
        logic [ADDR_W-1:0] delta;
        begin
            delta    = addr - base;
            in_table = (addr >= base) && (addr[2:0] == 3'h0)
                       && (int'(delta >> SLOT_SHIFT) < count);
        end
    endfunction

    // Slot number of an offset within a table
    function automatic logic [ADDR_W-1:0] slot_of(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] delta;
        begin
            delta   = addr - base;
            slot_of = delta >> SLOT_SHIFT;
        end
    endfunction

    msg_write_if mw ();

    logic                    ext_enable;
    logic                    hit_ext;
    logic                    hit_irq;
    logic                    hit_status;
    logic                    hit_ident;
    logic [EXT_INDEX_W-1:0]  ext_index;
    logic [IRQ_INDEX_W-1:0]  irq_index;
    logic                    ext_wr_en;
    logic [DATA_W-1:0]       ext_rd_data;
    logic [DATA_W-1:0]       status_word;
    logic [DATA_W-1:0]       read_word;
    logic [DATA_W-1:0]       cfg_slot [IRQ_COUNT-1];
    logic [DATA_W-1:0]       next_cfg_slot [IRQ_COUNT-1];
    logic [2:0]              next_clear;
    logic [DATA_W-1:0]       next_rdata;
    logic                    next_ack;
    logic [2:0]              next_wbusy;
    logic [2:0]              next_werror;
    answer_state_type        state;
    answer_state_type        next_state;

    // Extension slots exist only without injection and few records
    assign ext_enable = EXT_IMPL && !fault_inject_present
                        && (record_count_field <= MAX_RECORDS);

    // Address decode; misaligned offsets are treated as unmapped
    always_comb
    begin
        hit_ext    = in_table(bus_addr, EXT_BASE, EXT_COUNT);
        hit_irq    = in_table(bus_addr, IRQ_BASE, IRQ_COUNT) && IRQ_CFG_IMPL;
        hit_status = hit_irq && (bus_addr == STATUS_OFFSET);
        hit_ident  = (bus_addr == IDENT_OFFSET) && IDENT_IMPL;
        ext_index  = EXT_INDEX_W'(slot_of(bus_addr, EXT_BASE));
        irq_index  = IRQ_INDEX_W'(slot_of(bus_addr, IRQ_BASE));
    end

    assign ext_wr_en = bus_req && bus_write && hit_ext && ext_enable;

    ext_slot_store u_ext_store (
        .core_clk (core_clk),
        .wr_en    (ext_wr_en),
        .wr_index (ext_index),
        .wr_data  (bus_wdata),
        .rd_index (ext_index),
        .rd_data  (ext_rd_data)
    );

    // Event pulses pass straight to the tracker
    assign mw.start = msg_start;
    assign mw.done  = msg_done;
    assign mw.err   = msg_err;
    assign mw.clear = next_clear;

    irq_write_tracker u_tracker (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .mw       (mw)
    );

    // Status word in the recommended layout; upper bits stay zero
    always_comb
    begin
        status_word                 = RESET_WORD;
        status_word[FAULT_BUSY_BIT] = mw.busy[0];
        status_word[FAULT_ERR_BIT]  = mw.error[0];
        status_word[RECOV_BUSY_BIT] = mw.busy[1];
        status_word[RECOV_ERR_BIT]  = mw.error[1];
        status_word[CRIT_BUSY_BIT]  = mw.busy[2];
        status_word[CRIT_ERR_BIT]   = mw.error[2];
        if (!RECOMMENDED)
        begin
            // Other layouts are free to define every bit
            status_word = RESET_WORD;
        end
    end

    // Write-one-to-clear of the error flags; zeros leave them alone
    always_comb
    begin
        next_clear = 3'h0;
        if (bus_req && bus_write && hit_status && RECOMMENDED)
        begin
            next_clear[0] = bus_wdata[FAULT_ERR_BIT];
            next_clear[1] = bus_wdata[RECOV_ERR_BIT];
            next_clear[2] = bus_wdata[CRIT_ERR_BIT];
        end
    end

    // Configuration slots 0 to 14; slot 15 is the status alias
    always_comb
    begin
        for (int i = 0; i < IRQ_COUNT - 1; i++)
        begin
            next_cfg_slot[i] = cfg_slot[i];
        end
        if (bus_req && bus_write && hit_irq && !hit_status)
        begin
            next_cfg_slot[irq_index] = bus_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < IRQ_COUNT - 1; i++)
            begin
                cfg_slot[i] <= RESET_WORD;
            end
        end
        else
        begin
            for (int i = 0; i < IRQ_COUNT - 1; i++)
            begin
                cfg_slot[i] <= next_cfg_slot[i];
            end
        end
    end

    // Read mux; anything unmapped or absent reads as zero
    always_comb
    begin
        read_word = RESET_WORD;
        if (hit_ext)
        begin
            if (ext_enable)
            begin
                read_word = ext_rd_data;
            end
        end
        else if (hit_status)
        begin
            read_word = status_word;
        end
        else if (hit_irq)
        begin
            read_word = cfg_slot[irq_index];
        end
        else if (hit_ident)
        begin
            // 32-bit register, upper part of the word stays zero
            read_word[7:0] = PART_LOW_VALUE;
        end
    end

    // One answer per request, one cycle after it is taken
    always_comb
    begin
        next_state  = state;
        next_ack    = 1'b0;
        next_rdata  = bus_rdata;
        next_wbusy  = mw.busy;
        next_werror = mw.error;
        case (state)
            ANS_IDLE:
            begin
                if (bus_req)
                begin
                    next_state = ANS_REPLY;
                    next_ack   = 1'b1;
                    next_rdata = bus_write ? RESET_WORD : read_word;
                end
            end
            ANS_REPLY:
            begin
                // Back-to-back requests are answered without a gap
                if (bus_req)
                begin
                    next_ack   = 1'b1;
                    next_rdata = bus_write ? RESET_WORD : read_word;
                end
                else
                begin
                    next_state = ANS_IDLE;
                end
            end
            default:
            begin
                next_state = ANS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state       <= ANS_IDLE;
            bus_ack     <= 1'b0;
            bus_rdata   <= RESET_WORD;
            write_busy  <= 3'h0;
            write_error <= 3'h0;
        end
        else
        begin
            state       <= next_state;
            bus_ack     <= next_ack;
            bus_rdata   <= next_rdata;
            write_busy  <= next_wbusy;
            write_error <= next_werror;
        end
    end
endmodule
`default_nettype wire

/* hw/err_group_pkg.sv */
// Constants for the error group interrupt status register block.
// Assumes a 4KB memory-mapped error record group on one core clock.
// Function
// - 192 read/write 64-bit extension slots from 0x800, only without injection, <=32 records.
// - Sixteen 64-bit interrupt configuration slots from 0xE80, zero when absent.
// - Status word at 0xEF8 aliases configuration slot 15, present only with configuration.
// - Bit 5 sets on critical write error, cleared by writing one.
// - Read-only bit 4 high while a critical message write is outstanding.
// - Bit 3 sets on recovery write error, cleared by writing one.
// - Read-only bit 2 high while a recovery message write is outstanding.
// - Bit 1 sets on fault-handling write error, cleared by writing one.
// - Read-only bit 0 high while a fault-handling message write is outstanding.
// - Busy bits follow outstanding message writes only, not interrupt assertion.
// - Error flags undefined at reset; absent types read zero; bits 63:6 zero.
// - Without recommended layout all status bits are implementation defined.
// - Read-only 32-bit identity at 0xFE0 holds part number bits 7:0; else zero.
// - Part number is 12 or 16 bits, leaving 8 or 4 revision bits.
// - Configuration, status and identity exist only inside a memory-mapped group.
package err_group_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 64;
    localparam int          KIND_COUNT      = 3;
    localparam logic [11:0] EXT_BASE        = 12'h800;
    localparam int          EXT_COUNT       = 192;
    localparam int          EXT_INDEX_W     = 8;
    localparam logic [11:0] IRQ_BASE        = 12'hE80;
    localparam int          IRQ_COUNT       = 16;
    localparam int          IRQ_INDEX_W     = 4;
    localparam logic [3:0]  STATUS_INDEX    = 4'hF;
    localparam logic [11:0] STATUS_OFFSET   = 12'hEF8;
    localparam logic [11:0] IDENT_OFFSET    = 12'hFE0;
    localparam int          SLOT_SHIFT      = 3;
    localparam logic [15:0] MAX_RECORDS     = 16'h0020;
    // Status bit positions, two per interrupt kind
    localparam int          FAULT_BUSY_BIT  = 0;
    localparam int          FAULT_ERR_BIT   = 1;
    localparam int          RECOV_BUSY_BIT  = 2;
    localparam int          RECOV_ERR_BIT   = 3;
    localparam int          CRIT_BUSY_BIT   = 4;
    localparam int          CRIT_ERR_BIT    = 5;
    // Kind index: 0 fault handling, 1 recovery, 2 critical
    localparam logic [2:0]  KIND_IMPL       = 3'h7;
    localparam bit          EXT_IMPL        = 1'b1;
    localparam bit          IRQ_CFG_IMPL    = 1'b1;
    localparam bit          RECOMMENDED     = 1'b1;
    localparam bit          IDENT_IMPL      = 1'b1;
    localparam int          PART_NUMBER_W   = 12;
    // Arbitrary value, not any real part
    localparam logic [7:0]  PART_LOW_VALUE  = 8'h5A;
    localparam logic [63:0] RESET_WORD      = 64'h0;
    typedef enum logic [0:0] {ANS_IDLE, ANS_REPLY} answer_state_type;
endpackage

/* hw/msg_write_if.sv */
// Carrier between the register front end and the message write tracker.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`default_nettype none
interface msg_write_if;
    logic [2:0] start;
    logic [2:0] done;
    logic [2:0] err;
    logic [2:0] clear;
    logic [2:0] busy;
    logic [2:0] error;
    modport tracker (input start, input done, input err, input clear,
                     output busy, output error);
    modport regs (output start, output done, output err, output clear,
                  input busy, input error);
endinterface
`default_nettype wire

/* hw/ext_slot_store.sv */
// Storage for the implementation-defined extension slots.
// Assumes writes and read index come from the register front end.
`timescale 1ns/10ps
`default_nettype none
module ext_slot_store
    import err_group_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   wr_en,
    input  wire logic [EXT_INDEX_W-1:0] wr_index,
    input  wire logic [DATA_W-1:0]      wr_data,
    input  wire logic [EXT_INDEX_W-1:0] rd_index,
    output logic      [DATA_W-1:0]      rd_data
);
    // No reset so the array can map onto RAM cells
    logic [DATA_W-1:0] slot [EXT_COUNT];

    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            slot[wr_index] <= wr_data;
        end
    end

    assign rd_data = slot[rd_index];
endmodule
`default_nettype wire

/* hw/irq_write_tracker.sv */
// Tracks outstanding message writes and sticky write errors per kind.
// Assumes start, done and err are single-cycle pulses on core_clk.
`timescale 1ns/10ps
`default_nettype none
module irq_write_tracker
    import err_group_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    msg_write_if.tracker mw
);
    logic [2:0] busy;
    logic [2:0] error;
    logic [2:0] next_busy;
    logic [2:0] next_error;

    always_comb
    begin
        // A new start wins over a done in the same cycle
        next_busy  = (mw.start | (busy & ~mw.done)) & KIND_IMPL;
        // An error arriving with a clear is kept
        next_error = ((mw.done & mw.err) | (error & ~mw.clear)) & KIND_IMPL;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy  <= 3'h0;
            error <= 3'h0;
        end
        else
        begin
            busy  <= next_busy;
            error <= next_error;
        end
    end

    assign mw.busy  = busy;
    assign mw.error = error;
endmodule
`default_nettype wire

/* verif/error_group_irq_status_regs_properties.sv */
// Concurrent checks on the ports of the error group register block.
// Assumes it is bound onto the top module; one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module error_group_irq_status_regs_properties
    import err_group_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic                  bus_req,
    input wire logic                  bus_write,
    input wire logic [ADDR_W-1:0]     bus_addr,
    input wire logic [DATA_W-1:0]     bus_wdata,
    input wire logic [DATA_W-1:0]     bus_rdata,
    input wire logic                  bus_ack,
    input wire logic                  fault_inject_present,
    input wire logic [15:0]           record_count_field,
    input wire logic [KIND_COUNT-1:0] msg_start,
    input wire logic [KIND_COUNT-1:0] msg_done,
    input wire logic [KIND_COUNT-1:0] msg_err,
    input wire logic [KIND_COUNT-1:0] write_busy,
    input wire logic [KIND_COUNT-1:0] write_error
);
    logic st_wr;
    logic st_rd;
    assign st_wr = bus_req && bus_write && bus_addr == STATUS_OFFSET;
    assign st_rd = bus_req && !bus_write && bus_addr == STATUS_OFFSET;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_ack_next; bus_req |=> bus_ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_idle; !bus_req |=> !bus_ack; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("spurious ack");
    property p_rdata_hold; !bus_ack |-> $stable(bus_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    property p_status_upper; st_rd |=> bus_rdata[63:6] == 58'h0; endproperty
    a_status_upper: assert property (p_status_upper) else $error("upper bits set");
    property p_ident;
        bus_req && !bus_write && bus_addr == IDENT_OFFSET |=> bus_rdata == {56'h0, PART_LOW_VALUE};
    endproperty
    a_ident: assert property (p_ident) else $error("identity wrong");
    property p_crit_busy; msg_start[2] |=> ##1 write_busy[2]; endproperty
    a_crit_busy: assert property (p_crit_busy) else $error("critical busy late");
    property p_recov_done; msg_done[1] && !msg_start[1] |=> ##1 !write_busy[1]; endproperty
    a_recov_done: assert property (p_recov_done) else $error("recovery busy stuck");
    property p_fault_err; msg_done[0] && msg_err[0] |=> ##1 write_error[0]; endproperty
    a_fault_err: assert property (p_fault_err) else $error("fault error not set");
    // Sticky flag may only drop two cycles after a one written to its bit
    property p_crit_clear; $fell(write_error[2]) |-> $past(st_wr && bus_wdata[5], 2); endproperty
    a_crit_clear: assert property (p_crit_clear) else $error("critical error lost");
    c_crit_err: cover property (msg_done[2] && msg_err[2]);
    c_w1c: cover property (st_wr && bus_wdata[5]);
    c_ident: cover property (bus_req && bus_addr == IDENT_OFFSET);
endmodule
bind error_group_irq_status_regs error_group_irq_status_regs_properties u_props (
    .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .fault_inject_present(fault_inject_present), .record_count_field(record_count_field),
    .msg_start(msg_start), .msg_done(msg_done), .msg_err(msg_err),
    .write_busy(write_busy), .write_error(write_error));
`default_nettype wire

/* verif/error_group_irq_status_regs_tb.sv */
// Self-checking bench for the error group register block.
// Assumes the checker file is compiled alongside; drives inputs at falling edges.
`timescale 1ns/10ps
`default_nettype none
module error_group_irq_status_regs_tb;
    import err_group_pkg::*;
    logic                  core_clk;
    logic                  rst_n;
    logic                  bus_req;
    logic                  bus_write;
    logic                  bus_ack;
    logic                  fault_inject_present;
    logic [ADDR_W-1:0]     bus_addr;
    logic [DATA_W-1:0]     bus_wdata;
    logic [DATA_W-1:0]     bus_rdata;
    logic [DATA_W-1:0]     q;
    logic [DATA_W-1:0]     d;
    logic [15:0]           record_count_field;
    logic [KIND_COUNT-1:0] msg_start;
    logic [KIND_COUNT-1:0] msg_done;
    logic [KIND_COUNT-1:0] msg_err;
    logic [KIND_COUNT-1:0] write_busy;
    logic [KIND_COUNT-1:0] write_error;
    logic [2:0]            busy_m;
    logic [2:0]            err_m;
    logic [31:0]           seed;
    int                    num_errors;
    int                    cmp_count;
    int                    cycles;
    int                    idx;
    error_group_irq_status_regs dut (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .fault_inject_present(fault_inject_present),
        .record_count_field(record_count_field), .msg_start(msg_start), .msg_done(msg_done),
        .msg_err(msg_err), .write_busy(write_busy), .write_error(write_error));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [63:0] exp_status(input logic [2:0] b, input logic [2:0] e);
        return {58'h0, e[2], b[2], e[1], b[1], e[0], b[0]};
    endfunction
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Holds the request over one edge, then idles a cycle so strobes never toggle twice
    task automatic access(input logic wr, input logic [11:0] a, input logic [63:0] wd);
        bus_req = 1'b1;
        bus_write = wr;
        bus_addr = a;
        bus_wdata = wd;
        @(negedge core_clk);
        bus_req = 1'b0;
        check("ack", 64'h1, {63'h0, bus_ack});
        q = bus_rdata;
        @(negedge core_clk);
    endtask
    task automatic pulse(input logic [2:0] s, input logic [2:0] dn, input logic [2:0] e);
        msg_start = s;
        msg_done = dn;
        msg_err = e;
        @(negedge core_clk);
        msg_start = 3'h0;
        msg_done = 3'h0;
        msg_err = 3'h0;
        @(negedge core_clk);
    endtask
    task automatic rd_status();
        access(1'b0, STATUS_OFFSET, 64'h0);
        check("status", exp_status(busy_m, err_m), q);
        check("busy_out", {61'h0, busy_m}, {61'h0, write_busy});
        check("error_out", {61'h0, err_m}, {61'h0, write_error});
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run is under two hundred cycles; the ceiling only catches a hang
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end
    initial
    begin
        seed = 32'h9F42;
        {rst_n, bus_req, bus_write, bus_addr, bus_wdata, fault_inject_present} = '0;
        {msg_start, msg_done, msg_err, busy_m, err_m} = '0;
        record_count_field = 16'h0020;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        rd_status();
        access(1'b0, IRQ_BASE, 64'h0);
        check("cfg_reset", 64'h0, q);
        access(1'b0, IDENT_OFFSET, 64'h0);
        check("ident", {56'h0, PART_LOW_VALUE}, q);
        access(1'b1, IDENT_OFFSET, {xs(), xs()});
        access(1'b0, IDENT_OFFSET, 64'h0);
        check("ident_ro", {56'h0, PART_LOW_VALUE}, q);
        access(1'b0, 12'hE84, 64'h0);
        check("misaligned", 64'h0, q);
        access(1'b0, 12'h100, 64'h0);
        check("unmapped", 64'h0, q);
        for (int i = 0; i < 15; i++)
        begin
            d = {xs(), xs()};
            access(1'b1, 12'(IRQ_BASE + i * 8), d);
            access(1'b0, 12'(IRQ_BASE + i * 8), 64'h0);
            check("cfg_slot", d, q);
        end
        for (int j = 0; j < 6; j++)
        begin
            idx = (j == 0) ? 0 : (j == 1) ? 191 : int'(xs() % 192);
            d = {xs(), xs()};
            access(1'b1, 12'(EXT_BASE + idx * 8), d);
            access(1'b0, 12'(EXT_BASE + idx * 8), 64'h0);
            check("ext_slot", d, q);
        end
        record_count_field = 16'h0021;
        access(1'b0, 12'(EXT_BASE + idx * 8), 64'h0);
        check("ext_many", 64'h0, q);
        record_count_field = 16'h0020;
        fault_inject_present = 1'b1;
        access(1'b0, 12'(EXT_BASE + idx * 8), 64'h0);
        check("ext_inject", 64'h0, q);
        fault_inject_present = 1'b0;
        // Per kind: busy on start, sticky error on failed done, a zero write keeps it, a one clears it
        for (int k = 0; k < 3; k++)
        begin
            pulse(3'(1 << k), 3'h0, 3'h0);
            busy_m[k] = 1'b1;
            rd_status();
            pulse(3'h0, 3'(1 << k), 3'(1 << k));
            busy_m[k] = 1'b0;
            err_m[k] = 1'b1;
            rd_status();
            access(1'b1, STATUS_OFFSET, 64'h0);
            rd_status();
            d = {xs(), xs()};
            d[5:0] = 6'h0;
            d[2 * k + 1] = 1'b1;
            access(1'b1, STATUS_OFFSET, d);
            err_m[k] = 1'b0;
            rd_status();
        end
        pulse(3'h7, 3'h0, 3'h0);
        busy_m = 3'h7;
        access(1'b1, STATUS_OFFSET, 64'h15);
        rd_status();
        pulse(3'h0, 3'h0, 3'h7);
        rd_status();
        pulse(3'h0, 3'h7, 3'h0);
        busy_m = 3'h0;
        rd_status();
        complete_run();
    end
endmodule
`default_nettype wire
